/* hw/tm2_pkg.sv */
/*
  tm2_pkg: constants shared by the timer end, the controller end and the
  interface that joins them.
  assumes: nothing; imported by no file, every use is tm2_pkg::name.
*/
package tm2_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int CTL_W = 8;
  localparam int SETUP_W = 2;

  // ------------------------------------------------------------------
  // timer control byte bit positions
  // ------------------------------------------------------------------
  localparam int CTL_OVERFLOW_FLAG = 7;
  localparam int CTL_EXTERNAL_FLAG = 6;
  localparam int CTL_RX_CLOCK_SELECT = 5;
  localparam int CTL_TX_CLOCK_SELECT = 4;
  localparam int CTL_TRIGGER_ENABLE = 3;
  localparam int CTL_TIMER_RUN = 2;
  localparam int CTL_COUNTER_SELECT = 1;
  localparam int CTL_CAPTURE_RELOAD_SELECT = 0;

  // setup bits: six-clock mode and timer interrupt enable
  localparam int SETUP_SIX_CLOCK = 0;
  localparam int SETUP_IRQ_ENABLE = 1;

  // ------------------------------------------------------------------
  // reset values and counter top value
  // ------------------------------------------------------------------
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [1:0] SETUP_RESET = 2'h0;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // ------------------------------------------------------------------
  // rate constants, in oscillator (aclk) cycles; SER_DIV_LAST counts overflow pulses
  // ------------------------------------------------------------------
  localparam logic [3:0] MC_DIV_SIX = 4'h6;
  localparam logic [3:0] MC_DIV_TWELVE = 4'hc;
  localparam logic [3:0] BAUD_DIV_SIX = 4'h1;
  localparam logic [3:0] BAUD_DIV_TWELVE = 4'h2;
  localparam logic [3:0] SER_DIV_LAST = 4'hf;

  // ------------------------------------------------------------------
  // command selects on the link
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TM2_SEL_CTL = 2'h0,
    TM2_SEL_COUNT = 2'h1,
    TM2_SEL_RELOAD = 2'h2,
    TM2_SEL_SETUP = 2'h3
  } tm2_sel_t;

  // ------------------------------------------------------------------
  // axi4-lite byte offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_CTL = 4'h0;
  localparam logic [3:0] OFS_COUNT = 4'h4;
  localparam logic [3:0] OFS_RELOAD = 4'h8;
  localparam logic [3:0] OFS_SETUP = 4'hc;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hw/tm2_if.sv */
/*
  tm2_if: command and state link between the timer end and its controller.
  assumes: both ends run on aclk; commands are one-cycle strobes.
*/
`timescale 1ns/1ps
interface tm2_if (
  input wire logic aclk,
  input wire logic aresetn
);
  // command from controller
  logic cmd_valid;
  tm2_pkg::tm2_sel_t cmd_sel;
  logic [15:0] cmd_data;
  // state from timer
  logic [7:0] ctl_q;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic [1:0] setup_q;

  modport timer (
    input cmd_valid, cmd_sel, cmd_data,
    output ctl_q, count_q, reload_q, setup_q
  );

  modport ctrl (
    output cmd_valid, cmd_sel, cmd_data,
    input ctl_q, count_q, reload_q, setup_q
  );
endinterface

/* hw/tm2_timer.sv */
/*
  tm2_timer: 16-bit timer with reload/capture pair and baud generator.
  assumes: aclk is the oscillator; pins are synchronous to aclk; the
  controller end issues one-cycle commands over tm2_if.
*/
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module tm2_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link to controller
  tm2_if.timer link,
  // pins
  input wire logic count_pin,
  input wire logic trigger_pin,
  // other timer overflow pulse
  input wire logic other_ovf,
  // serial port clocks
  output logic tx_bit_tick,
  output logic rx_bit_tick,
  // interrupt request
  output logic irq_req
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] ctl_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic [1:0] setup_r;
  logic [3:0] presc_r;
  logic count_pin_r;
  logic trigger_pin_r;
  logic [1:0] ser_tick_r;
  logic irq_r;

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  logic run;
  logic baud;
  logic capture;
  logic six_clock;
  logic wr_ctl;
  logic wr_count;
  logic wr_reload;
  logic wr_setup;

  assign run = ctl_r[tm2_pkg::CTL_TIMER_RUN];
  assign baud = ctl_r[tm2_pkg::CTL_TX_CLOCK_SELECT] | ctl_r[tm2_pkg::CTL_RX_CLOCK_SELECT];
  assign capture = ~baud & ctl_r[tm2_pkg::CTL_CAPTURE_RELOAD_SELECT];
  assign six_clock = setup_r[tm2_pkg::SETUP_SIX_CLOCK];

  assign wr_ctl = link.cmd_valid && (link.cmd_sel == tm2_pkg::TM2_SEL_CTL);
  assign wr_count = link.cmd_valid && (link.cmd_sel == tm2_pkg::TM2_SEL_COUNT);
  assign wr_reload = link.cmd_valid && (link.cmd_sel == tm2_pkg::TM2_SEL_RELOAD);
  assign wr_setup = link.cmd_valid && (link.cmd_sel == tm2_pkg::TM2_SEL_SETUP);

  // ------------------------------------------------------------------
  // internal clock prescaler
  // ------------------------------------------------------------------
  logic [3:0] presc_last;
  logic int_tick;

  always_comb begin
    if (baud) begin
      presc_last = six_clock ? tm2_pkg::BAUD_DIV_SIX : tm2_pkg::BAUD_DIV_TWELVE;
    end else begin
      presc_last = six_clock ? tm2_pkg::MC_DIV_SIX : tm2_pkg::MC_DIV_TWELVE;
    end
  end

  assign int_tick = (presc_r >= presc_last - 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 4'h0;
    end else if (!run || int_tick) begin
      presc_r <= 4'h0;
    end else begin
      presc_r <= presc_r + 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // pin edge detection
  // ------------------------------------------------------------------
  logic count_fall;
  logic trigger_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_pin_r <= 1'b1;
      trigger_pin_r <= 1'b1;
    end else begin
      count_pin_r <= count_pin;
      trigger_pin_r <= trigger_pin;
    end
  end

  assign count_fall = count_pin_r & ~count_pin;
  assign trigger_fall = trigger_pin_r & ~trigger_pin;

  // ------------------------------------------------------------------
  // count events
  // ------------------------------------------------------------------
  logic inc;
  logic own_ovf;
  logic trig_evt;
  logic trig_load;
  logic trig_capture;

  assign inc = run & (ctl_r[tm2_pkg::CTL_COUNTER_SELECT] ? count_fall : int_tick);
  assign own_ovf = inc & (count_r == tm2_pkg::CNT_MAX);
  assign trig_evt = run & ctl_r[tm2_pkg::CTL_TRIGGER_ENABLE] & trigger_fall;
  assign trig_load = trig_evt & ~baud & ~capture;
  assign trig_capture = trig_evt & capture;

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= tm2_pkg::CNT_RESET;
    end else if (wr_count) begin
      count_r <= link.cmd_data;
    end else if (trig_load) begin
      count_r <= reload_r;
    end else if (own_ovf && !capture) begin
      count_r <= reload_r;
    end else if (inc) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // reload / capture pair
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_r <= tm2_pkg::CNT_RESET;
    end else if (wr_reload) begin
      reload_r <= link.cmd_data;
    end else if (trig_capture) begin
      reload_r <= count_r;
    end
  end

  // ------------------------------------------------------------------
  // control byte and flags; hardware set wins over software clear
  // ------------------------------------------------------------------
  logic set_ovf_flag;

  assign set_ovf_flag = own_ovf & ~baud;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= tm2_pkg::CTL_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_r <= link.cmd_data[7:0];
      end
      if (set_ovf_flag) begin
        ctl_r[tm2_pkg::CTL_OVERFLOW_FLAG] <= 1'b1;
      end
      if (trig_evt) begin
        ctl_r[tm2_pkg::CTL_EXTERNAL_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_r <= tm2_pkg::SETUP_RESET;
    end else if (wr_setup) begin
      setup_r <= link.cmd_data[1:0];
    end
  end

  // ------------------------------------------------------------------
  // serial clocks: source select and divide by 16
  // ------------------------------------------------------------------
  logic [1:0] dir_sel;

  assign dir_sel[0] = ctl_r[tm2_pkg::CTL_TX_CLOCK_SELECT];
  assign dir_sel[1] = ctl_r[tm2_pkg::CTL_RX_CLOCK_SELECT];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ser
      logic [3:0] div_r;
      logic src;

      assign src = dir_sel[g] ? own_ovf : other_ovf;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          div_r <= 4'h0;
          ser_tick_r[g] <= 1'b0;
        end else begin
          ser_tick_r[g] <= src && (div_r == tm2_pkg::SER_DIV_LAST);
          if (src) begin
            div_r <= div_r + 4'h1;
          end
        end
      end
    end
  endgenerate

  assign tx_bit_tick = ser_tick_r[0];
  assign rx_bit_tick = ser_tick_r[1];

  // ------------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= setup_r[tm2_pkg::SETUP_IRQ_ENABLE] &
               (ctl_r[tm2_pkg::CTL_OVERFLOW_FLAG] | ctl_r[tm2_pkg::CTL_EXTERNAL_FLAG]);
    end
  end

  assign irq_req = irq_r;

  // ------------------------------------------------------------------
  // state to controller
  // ------------------------------------------------------------------
  assign link.ctl_q = ctl_r;
  assign link.count_q = count_r;
  assign link.reload_q = reload_r;
  assign link.setup_q = setup_r;

endmodule // tm2_timer

/* hw/tm2_ctrl.sv */
/*
  tm2_ctrl: axi4-lite slave that turns software accesses into timer
  commands and returns timer state.
  assumes: one write and one read at most outstanding; aclk shared.
*/
`timescale 1ns/1ps
module tm2_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link to timer
  tm2_if.ctrl link
);

  // ------------------------------------------------------------------
  // write channel capture
  // ------------------------------------------------------------------
  logic aw_held_r;
  logic [3:0] awaddr_r;
  logic w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (aw_held_r && w_held_r) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (aw_held_r && w_held_r) begin
      w_held_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // write decode and command issue
  // ------------------------------------------------------------------
  logic do_wr;
  logic mapped;
  logic baud_running;
  logic blocked;
  tm2_pkg::tm2_sel_t sel;

  assign do_wr = aw_held_r & w_held_r;
  assign baud_running = link.ctl_q[tm2_pkg::CTL_TIMER_RUN] &
                        (link.ctl_q[tm2_pkg::CTL_TX_CLOCK_SELECT] |
                         link.ctl_q[tm2_pkg::CTL_RX_CLOCK_SELECT]);

  always_comb begin
    mapped = 1'b1;
    sel = tm2_pkg::TM2_SEL_CTL;
    case (awaddr_r)
      tm2_pkg::OFS_CTL: sel = tm2_pkg::TM2_SEL_CTL;
      tm2_pkg::OFS_COUNT: sel = tm2_pkg::TM2_SEL_COUNT;
      tm2_pkg::OFS_RELOAD: sel = tm2_pkg::TM2_SEL_RELOAD;
      tm2_pkg::OFS_SETUP: sel = tm2_pkg::TM2_SEL_SETUP;
      default: mapped = 1'b0;
    endcase
  end

  // counter and reload writes dropped while the baud generator runs
  assign blocked = baud_running &&
                   (sel == tm2_pkg::TM2_SEL_COUNT || sel == tm2_pkg::TM2_SEL_RELOAD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.cmd_valid <= 1'b0;
      link.cmd_sel <= tm2_pkg::TM2_SEL_CTL;
      link.cmd_data <= 16'h0;
    end else begin
      link.cmd_valid <= do_wr && mapped && !blocked && (wstrb_r[0] || wstrb_r[1]);
      link.cmd_sel <= sel;
      link.cmd_data <= wdata_r[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= tm2_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped ? tm2_pkg::RESP_OKAY : tm2_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ------------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_arready = ~rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= tm2_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= tm2_pkg::RESP_OKAY;
      case (s_axi_araddr)
        tm2_pkg::OFS_CTL: rdata_r <= {24'h0, link.ctl_q};
        tm2_pkg::OFS_COUNT: rdata_r <= {16'h0, link.count_q};
        tm2_pkg::OFS_RELOAD: rdata_r <= {16'h0, link.reload_q};
        tm2_pkg::OFS_SETUP: rdata_r <= {30'h0, link.setup_q};
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= tm2_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule // tm2_ctrl

/* dv/tm2_link_monitor.sv */
/*
  tm2_link_monitor: assertions on the link between timer and controller.
  assumes: instantiated by the bench beside tm2_if, one aclk domain.
*/
`timescale 1ns/1ps
module tm2_link_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link signals
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_sel,
  input wire logic [15:0] cmd_data,
  input wire logic [7:0] ctl_q,
  input wire logic [15:0] count_q,
  input wire logic [15:0] reload_q,
  input wire logic [1:0] setup_q
);
  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  logic run, baud, rld, cap, b12;
  assign run = ctl_q[2];
  assign baud = run & (ctl_q[5] | ctl_q[4]);
  assign rld = run & (baud | !ctl_q[0]);
  assign cap = run & !baud & ctl_q[0];
  assign b12 = baud & !ctl_q[1] & !setup_q[0];

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  chk_run_clear_hold: assert property (
    (!run && !cmd_valid) |=> $stable(count_q)) else $error("count moved while stopped");
  chk_baud_no_ovf: assert property (
    (baud && !cmd_valid && !ctl_q[7]) |=> !ctl_q[7]) else $error("overflow flag set in baud");
  chk_reload_rollover: assert property (
    (rld && !cmd_valid && count_q == 16'hffff) ##1 (count_q != 16'hffff)
    |-> count_q == $past(reload_q)) else $error("rollover did not reload");
  chk_capture_wrap: assert property (
    (cap && !cmd_valid && count_q == 16'hffff) ##1 (count_q != 16'hffff)
    |-> count_q == 16'h0000) else $error("capture rollover not to zero");
  chk_ovf_flag_set: assert property (
    (run && !baud && !cmd_valid && count_q == 16'hffff) ##1 (count_q != 16'hffff && !cmd_valid)
    |-> ##[0:1] ctl_q[7]) else $error("overflow flag not set");
  chk_flags_sticky: assert property (
    !cmd_valid |=> (ctl_q[7:6] & $past(ctl_q[7:6])) == $past(ctl_q[7:6]))
    else $error("flag cleared by hardware");
  chk_baud12_period: assert property (
    (b12 && !cmd_valid && $changed(count_q)) |=> $stable(count_q))
    else $error("baud count too fast");
  chk_baud12_moves: assert property (
    (b12 && !cmd_valid) [*4] |-> count_q != $past(count_q, 3)) else $error("baud count stalled");
  chk_baud_no_load_cmd: assert property (
    baud |-> !(cmd_valid && (cmd_sel == tm2_pkg::TM2_SEL_COUNT || cmd_sel == tm2_pkg::TM2_SEL_RELOAD)))
    else $error("counter write passed in baud");
  chk_baud_reload_kept: assert property (
    (baud && !cmd_valid) |=> $stable(reload_q)) else $error("reload pair changed in baud");
  chk_reload_write_lands: assert property (
    (cmd_valid && cmd_sel == tm2_pkg::TM2_SEL_RELOAD) |=> reload_q == $past(cmd_data))
    else $error("reload pair write lost");

  // ------------------------------------------------------------------
  // covers
  // ------------------------------------------------------------------
  cover property (baud && count_q == 16'hffff);
  cover property (cap && ctl_q[7]);
  cover property (baud && ctl_q[6]);
endmodule // tm2_link_monitor

/* dv/testbench.sv */
/*
  testbench: timer and controller joined by tm2_if, driven over axi4-lite.
  assumes: design files and tm2_link_monitor compiled first.
*/
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam logic [3:0] C = tm2_pkg::OFS_CTL;
  localparam logic [3:0] K = tm2_pkg::OFS_COUNT;
  localparam logic [3:0] R = tm2_pkg::OFS_RELOAD;
  localparam logic [3:0] S = tm2_pkg::OFS_SETUP;
  localparam logic [1:0] OK = tm2_pkg::RESP_OKAY;
  localparam logic [1:0] ER = tm2_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic count_pin = 1'b1, trigger_pin = 1'b1, other_ovf = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_tick, rx_tick, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches = 0, checked = 0, ovf_cnt = 0;

  initial forever #12.5 aclk = ~aclk;

  // other timer overflow every 5 cycles
  always @(posedge aclk) begin
    ovf_cnt <= (ovf_cnt == 4) ? 0 : ovf_cnt + 1;
    other_ovf <= (ovf_cnt == 4);
  end

  // ------------------------------------------------------------------
  // design and monitor
  // ------------------------------------------------------------------
  tm2_if link_if (.aclk(aclk), .aresetn(aresetn));
  tm2_ctrl tm2_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_if));
  tm2_timer tm2_timer_i (.aclk(aclk), .aresetn(aresetn), .link(link_if),
    .count_pin(count_pin), .trigger_pin(trigger_pin), .other_ovf(other_ovf),
    .tx_bit_tick(tx_tick), .rx_bit_tick(rx_tick), .irq_req(irq));
  tm2_link_monitor tm2_link_monitor_i (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(link_if.cmd_valid), .cmd_sel(link_if.cmd_sel), .cmd_data(link_if.cmd_data),
    .ctl_q(link_if.ctl_q), .count_q(link_if.count_q), .reload_q(link_if.reload_q),
    .setup_q(link_if.setup_q));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    compare("write wait", 32'h0, (n == 100));
    if (n == 100)
      tally_and_finish();
    compare("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    compare("read wait", 32'h0, (n == 100));
    if (n == 100)
      tally_and_finish();
    compare("rdata", ed, rdata);
    compare("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // one falling edge on the trigger pin (trig=1) or the count pin
  task automatic fall(input bit trig);
    @(posedge aclk);
    if (trig) trigger_pin <= 1'b0;
    else count_pin <= 1'b0;
    cycles(3);
    if (trig) trigger_pin <= 1'b1;
    else count_pin <= 1'b1;
    cycles(3);
  endtask

  task automatic count_period(input int exp);
    int n;
    logic [15:0] v;
    v = link_if.count_q;
    for (n = 0; n < 40 && link_if.count_q === v; n++) @(posedge aclk);
    v = link_if.count_q;
    for (n = 0; n < 40 && link_if.count_q === v; n++) @(posedge aclk);
    compare("count period", exp, n);
  endtask

  task automatic tick_period(input bit rx, input int exp);
    int n, k;
    for (k = 0; k < 3; k++) begin
      for (n = 1; n < 400; n++) begin
        @(posedge aclk);
        if (rx ? rx_tick : tx_tick)
          break;
      end
    end
    compare("tick period", exp, n);
  endtask

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    int m;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(C, 32'h0, OK);
    axi_read(R, 32'h0, OK);
    axi_read(4'h2, 32'h0, ER);
    axi_write(4'h6, 32'h5, ER);
    axi_write(K, 32'h1234, OK);
    cycles(40);
    axi_read(K, 32'h1234, OK);
    axi_write(K, 32'h0, OK);
    for (m = 0; m < 4; m++) begin
      axi_write(S, {31'h0, m[0]}, OK);
      axi_write(C, m[1] ? 32'h34 : 32'h04, OK);
      count_period(m[1] ? (m[0] ? 1 : 2) : (m[0] ? 6 : 12));
      axi_write(C, 32'h0, OK);
    end
    axi_write(R, 32'hfffc, OK);
    axi_write(K, 32'hfffc, OK);
    axi_write(C, 32'h14, OK);
    tick_period(1'b0, 64);
    tick_period(1'b1, 80);
    axi_write(R, 32'h1111, OK);
    axi_write(C, 32'h24, OK);
    tick_period(1'b1, 64);
    tick_period(1'b0, 80);
    axi_write(S, 32'h0, OK);
    tick_period(1'b1, 128);
    axi_read(C, 32'h24, OK);
    axi_read(R, 32'hfffc, OK);
    axi_write(S, 32'h2, OK);
    axi_write(C, 32'h2c, OK);
    fall(1'b1);
    axi_read(C, 32'h6c, OK);
    compare("irq", 32'h1, irq);
    axi_read(R, 32'hfffc, OK);
    axi_write(C, 32'h2c, OK);
    cycles(2);
    compare("irq", 32'h0, irq);
    axi_write(C, 32'h0a, OK);
    axi_write(K, 32'h1000, OK);
    axi_write(R, 32'h0055, OK);
    axi_write(C, 32'h0e, OK);
    fall(1'b1);
    axi_read(K, 32'h0055, OK);
    axi_read(C, 32'h4e, OK);
    repeat (3) fall(1'b0);
    axi_read(K, 32'h0058, OK);
    axi_write(C, 32'h0f, OK);
    fall(1'b1);
    axi_read(R, 32'h0058, OK);
    axi_read(K, 32'h0058, OK);
    axi_write(C, 32'h07, OK);
    fall(1'b1);
    axi_read(C, 32'h07, OK);
    axi_write(C, 32'h03, OK);
    axi_write(K, 32'hfffe, OK);
    axi_write(C, 32'h07, OK);
    repeat (2) fall(1'b0);
    axi_read(K, 32'h0, OK);
    axi_read(C, 32'h87, OK);
    axi_write(C, 32'h02, OK);
    axi_write(K, 32'hfffe, OK);
    axi_write(C, 32'h06, OK);
    repeat (2) fall(1'b0);
    axi_read(K, 32'h0058, OK);
    axi_read(C, 32'h86, OK);
    axi_write(C, 32'h02, OK);
    fall(1'b0);
    axi_read(K, 32'h0058, OK);
    tally_and_finish();
  end
endmodule // testbench
